// >>> design/bsp_consts.vh
// constants for the barometer serial command port
// assumes inclusion by bare name from the design files
`ifndef BSP_CONSTS_VH
`define BSP_CONSTS_VH
// framing group lengths
`define BSP_START_BITS   3
`define BSP_STOP_BITS    3
`define BSP_SETUP_BITS   4
`define BSP_RESET_BITS   21
// setup codes; chosen values, configurable
`define BSP_CODE_PRESS   4'hA
`define BSP_CODE_TEMP    4'h9
`define BSP_CODE_CAL1    4'h5
`define BSP_CODE_CAL2    4'h6
`define BSP_CODE_CAL3    4'h3
`define BSP_CODE_CAL4    4'hC
// reset pattern, sent first bit in the msb
`define BSP_RESET_PAT    21'h155540
// result width and readout clocks
`define BSP_WORD_BITS    16
`define BSP_READ_CLKS    17
// master clock and conversion length in master clock periods
`define BSP_MCLK_HZ      32768
`define BSP_CONV_MCLKS   16'h0100
`endif

// >>> design/bsp_skid.v
// two-entry buffer with valid and ready on both sides
// assumes one clock, synchronous active-low reset, clock enable freezes it
module bsp_skid #(
    parameter W = 16
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    // filling side
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    // draining side
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg [W-1:0] mem_r [0:1];
    reg         wp_r;
    reg         rp_r;
    reg [1:0]   cnt_r;
    wire        push;
    wire        pop;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    ////////////////////////////////////////////////////////////////////////
    // pointers and count; a full buffer stalls the writer
    always @(posedge clk) begin
        if (!rst_n) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else if (ce) begin
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r        <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule

// >>> design/bsp_port.v
// serial command and readout port of a pressure and temperature sensor
// assumes sclk, din and mclk come from off-chip and are sampled by clk
// Notes on behaviour
// - controller changes din after sclk falls; device captures din on sclk rise
// - dout updates on each sclk rising edge while shifting data out
// - dout carries result, calibration or status chosen by last instruction
// - seven instructions: pressure, temperature, four calibration words, reset
// - no select line; every transaction starts with an instruction on din
// - three high bits start an instruction
// - three low bits after setup close the instruction
// - four setup bits select pressure, temperature or a calibration word
// - conversion start acknowledged by dout rising during last stop bit
// - sclk held low while converting; dout falling marks completion
// - after completion 17 sclk pulses shift out the 16-bit result
// - held sclk pauses readout; shift position kept and resumed
// - 21-bit reset pattern recognised in any state returns to idle
// - 64-bit read-only calibration store readable by instructions
// - calibration store is four 16-bit words, one instruction each
// - converter runs from separate 32.768 kHz master clock
// - pressure and temperature results are 16-bit unsigned words
`include "bsp_consts.vh"
module bsp_port #(
    parameter [15:0] CAL_W1    = 16'h1111,
    parameter [15:0] CAL_W2    = 16'h2222,
    parameter [15:0] CAL_W3    = 16'h3333,
    parameter [15:0] CAL_W4    = 16'h4444,
    parameter [15:0] CONV_MCLK = `BSP_CONV_MCLKS
) (
    // clock, reset, enable
    clk,
    rst_n,
    ce,
    // serial link pins
    sclk,
    din,
    dout,
    // converter master clock pin
    mclk,
    // converter result stream from the analogue side
    adc_data,
    adc_valid,
    adc_ready,
    // conversion request and status towards the analogue side
    conv_start,
    conv_is_temp,
    busy
);
    input  wire        clk;
    input  wire        rst_n;
    input  wire        ce;
    input  wire        sclk;
    input  wire        din;
    output reg         dout;
    input  wire        mclk;
    input  wire [15:0] adc_data;
    input  wire        adc_valid;
    output wire        adc_ready;
    output reg         conv_start;
    output reg         conv_is_temp;
    output reg         busy;

    // states, one-hot
    localparam [5:0] S_IDLE = 6'h01;  // waiting for start group
    localparam [5:0] S_HDR  = 6'h02;  // collecting setup and stop
    localparam [5:0] S_ACK  = 6'h04;  // two clocks after acknowledge
    localparam [5:0] S_CONV = 6'h08;  // converting, sclk low
    localparam [5:0] S_WAIT = 6'h10;  // waiting for word from buffer
    localparam [5:0] S_SHFT = 6'h20;  // shifting result or calibration word out
    // readout clock count sized to the bit counter
    localparam [4:0] READ_CLKS = `BSP_READ_CLKS;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; first stage feeds only the second
    reg [1:0] sclk_s_r;
    reg [1:0] din_s_r;
    reg [1:0] mclk_s_r;
    reg       sclk_d_r;
    reg       mclk_d_r;
    always @(posedge clk) begin
        if (!rst_n) begin
            sclk_s_r <= 2'h0;
            din_s_r  <= 2'h0;
            mclk_s_r <= 2'h0;
            sclk_d_r <= 1'b0;
            mclk_d_r <= 1'b0;
        end else if (ce) begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            din_s_r  <= {din_s_r[0], din};
            mclk_s_r <= {mclk_s_r[0], mclk};
            sclk_d_r <= sclk_s_r[1];
            mclk_d_r <= mclk_s_r[1];
        end
    end
    wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    wire mclk_rise = mclk_s_r[1] & ~mclk_d_r;
    wire din_bit   = din_s_r[1];

    ////////////////////////////////////////////////////////////////////////
    // calibration store lookup, read only
    function [15:0] cal_word;
        input [1:0] idx;
        begin
            case (idx)
                2'h0:    cal_word = CAL_W1;
                2'h1:    cal_word = CAL_W2;
                2'h2:    cal_word = CAL_W3;
                default: cal_word = CAL_W4;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // result buffer between converter and serial shifter
    wire [15:0] buf_data;
    wire        buf_valid;
    reg         buf_pop;
    bsp_skid #(
        .W (16)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_data   (adc_data),
        .in_valid  (adc_valid),
        .in_ready  (adc_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop)
    );

    ////////////////////////////////////////////////////////////////////////
    // main protocol state
    reg [5:0]  st_r;
    reg [20:0] hist_r;   // last din bits for reset hunting
    reg [2:0]  ones_r;   // consecutive high bits seen in idle
    reg [2:0]  cnt_r;    // bits collected in header / ack clocks
    reg [6:0]  hdr_r;    // setup and stop bits
    reg [15:0] sh_r;     // outgoing word
    reg [4:0]  bit_r;    // readout clocks left
    reg [15:0] conv_r;   // master clock periods left
    reg        conv_req_r;
    wire [20:0] hist_nxt = {hist_r[19:0], din_bit};
    wire [6:0]  hdr_nxt  = {hdr_r[5:0], din_bit};
    wire [3:0]  code     = hdr_nxt[6:3];

    always @(posedge clk) begin
        if (!rst_n) begin
            st_r         <= S_IDLE;
            hist_r       <= 21'h000000;
            ones_r       <= 3'h0;
            cnt_r        <= 3'h0;
            hdr_r        <= 7'h00;
            sh_r         <= 16'h0000;
            bit_r        <= 5'h00;
            conv_r       <= 16'h0000;
            conv_req_r   <= 1'b0;
            dout         <= 1'b0;
            conv_start   <= 1'b0;
            conv_is_temp <= 1'b0;
            busy         <= 1'b0;
            buf_pop      <= 1'b0;
        end else if (ce) begin
            conv_start <= 1'b0;
            buf_pop    <= 1'b0;
            busy       <= (st_r != S_IDLE);
            if (sclk_rise)
                hist_r <= hist_nxt;
            if (sclk_rise && hist_nxt == `BSP_RESET_PAT) begin
                // reset pattern wins over any state
                st_r   <= S_IDLE;
                ones_r <= 3'h0;
                dout   <= 1'b0;
            end else begin
                case (st_r)
                    S_IDLE: begin
                        if (sclk_rise) begin
                            // instruction opens with start group
                            if (!din_bit)
                                ones_r <= 3'h0;
                            else if (ones_r == `BSP_START_BITS - 1) begin
                                ones_r <= 3'h0;
                                cnt_r  <= 3'h0;
                                st_r   <= S_HDR;
                            end else
                                ones_r <= ones_r + 3'h1;
                        end
                    end
                    S_HDR: begin
                        if (sclk_rise) begin
                            hdr_r <= hdr_nxt;
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r == `BSP_SETUP_BITS + `BSP_STOP_BITS - 1) begin
                                // stop group must be all low to close
                                if (hdr_nxt[2:0] != 3'h0)
                                    st_r <= S_IDLE;
                                else if (code == `BSP_CODE_PRESS ||
                                         code == `BSP_CODE_TEMP) begin
                                    dout         <= 1'b1;
                                    conv_is_temp <= (code == `BSP_CODE_TEMP);
                                    conv_start   <= 1'b1;
                                    conv_req_r   <= 1'b1;
                                    conv_r       <= CONV_MCLK;
                                    cnt_r        <= 3'h0;
                                    st_r         <= S_ACK;
                                end else begin
                                    // calibration words need no wait
                                    case (code)
                                        `BSP_CODE_CAL1: sh_r <= cal_word(2'h0);
                                        `BSP_CODE_CAL2: sh_r <= cal_word(2'h1);
                                        `BSP_CODE_CAL3: sh_r <= cal_word(2'h2);
                                        default:        sh_r <= cal_word(2'h3);
                                    endcase
                                    bit_r <= READ_CLKS;
                                    st_r  <= (code == `BSP_CODE_CAL1 ||
                                              code == `BSP_CODE_CAL2 ||
                                              code == `BSP_CODE_CAL3 ||
                                              code == `BSP_CODE_CAL4) ?
                                             S_SHFT : S_IDLE;
                                end
                            end
                        end
                    end
                    S_ACK: begin
                        // two clocks after acknowledge, dout stays high
                        if (sclk_rise) begin
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r == 3'h1)
                                st_r <= S_CONV;
                        end
                    end
                    S_CONV: begin
                        // timed by the master clock, not by sclk
                        if (mclk_rise && conv_r != 16'h0000)
                            conv_r <= conv_r - 16'h0001;
                        if (conv_r == 16'h0000)
                            st_r <= S_WAIT;
                    end
                    S_WAIT: begin
                        // take the word; falling dout flags completion
                        if (buf_valid && !buf_pop) begin
                            sh_r       <= buf_data;
                            buf_pop    <= 1'b1;
                            conv_req_r <= 1'b0;
                            dout       <= 1'b0;
                            bit_r      <= READ_CLKS;
                            st_r       <= S_SHFT;
                        end
                    end
                    S_SHFT: begin
                        // one bit per rising edge, msb first; pause keeps place
                        if (sclk_rise) begin
                            dout  <= sh_r[15];
                            sh_r  <= {sh_r[14:0], 1'b0};
                            bit_r <= bit_r - 5'h01;
                            if (bit_r == 5'h01) begin
                                dout <= 1'b0;
                                st_r <= S_IDLE;
                            end
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// >>> test/bsp_mcu.sv
// controller model: makes sclk and drives din, samples dout
// assumes dout settles within a few system clocks of each sclk rise
module bsp_mcu (
    // serial pins towards the port
    output logic sclk,
    output logic din,
    input  wire  dout
);
    timeunit 1ns;
    timeprecision 100ps;

    // sclk stands low between frames
    initial begin
        sclk = 1'b0;
        din  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one 125 ns clock: din moves while sclk is low, never near the rise
    task automatic pulse(input logic b);
        din = b;
        #62.5 sclk = 1'b1;
        #62.5 sclk = 1'b0;
    endtask

    // n bits msb first
    task automatic send(input int n, input logic [20:0] bits);
        for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
    endtask

    // 17 clocks, one bit taken after each of the first 16 rises; pause_at holds sclk low
    task automatic rd(input int pause_at, output logic [15:0] w);
        w = 16'h0000;
        for (int i = 0; i < 17; i++) begin
            if (i == pause_at) #2000;
            pulse(1'b0);
            if (i < 16) w = {w[14:0], dout};
        end
    endtask
endmodule

// >>> test/bsp_port_assertions.sv
// pin-level checks on the serial command port
// assumes one clk domain, sclk sampled raw as the port sees it
module bsp_port_chk (
    // clock and control
    input wire        clk,
    input wire        rst_n,
    input wire        ce,
    // serial pins
    input wire        sclk,
    input wire        dout,
    // converter side
    input wire        adc_ready,
    input wire        conv_start,
    input wire        busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_start_pulse;
        conv_start |=> !conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
    property p_start_busy;
        conv_start |=> busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("idle after start");
    property p_ack;
        conv_start |-> ##[0:4] dout;
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge");
    property p_freeze;
        !ce |=> $stable({dout, busy, conv_start});
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved while frozen");
    property p_idle_low;
        !busy [*3] |-> !dout;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("dout high when idle");
    property p_rise_sclk;
        $rose(dout) |-> sclk;
    endproperty
    a_rise_sclk: assert property (p_rise_sclk) else $error("dout rose off sclk");
    property p_done_busy;
        $fell(dout) && !sclk |-> busy;
    endproperty
    a_done_busy: assert property (p_done_busy) else $error("completion when idle");
    property p_hold;
        (!sclk && !dout) [*8] |=> !dout;
    endproperty
    a_hold: assert property (p_hold) else $error("dout moved while held");
endmodule

bind bsp_port bsp_port_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk),
    .dout(dout), .adc_ready(adc_ready), .conv_start(conv_start), .busy(busy));

// >>> test/testbench.sv
// self-checking bench for the serial command port
// assumes the controller model drives the link, bench feeds converter words
`include "bsp_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rst_n, ce, mclk, adc_valid;
    logic [15:0] adc_data;
    wire         sclk, din, dout, adc_ready, conv_start, conv_is_temp, busy;
    int          n_errors, n_checks, n_starts;
    logic [15:0] words[$];
    localparam logic [15:0] CW [4] = '{16'hA5C3, 16'h0001, 16'hFFFE, 16'h8000};
    localparam logic [3:0]  CC [4] = '{`BSP_CODE_CAL1, `BSP_CODE_CAL2,
                                       `BSP_CODE_CAL3, `BSP_CODE_CAL4};

    bsp_port #(.CAL_W1(CW[0]), .CAL_W2(CW[1]), .CAL_W3(CW[2]), .CAL_W4(CW[3]),
        .CONV_MCLK(16'h0002)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk),
        .din(din), .dout(dout), .mclk(mclk), .adc_data(adc_data),
        .adc_valid(adc_valid), .adc_ready(adc_ready), .conv_start(conv_start),
        .conv_is_temp(conv_is_temp), .busy(busy));
    bsp_mcu u_mcu (.sclk(sclk), .din(din), .dout(dout));

    ////////////////////////////////////////////////////////////////////////
    // clocks: 100 MHz system, 32.768 kHz master
    always #5 clk = ~clk;
    always #15259 mclk = ~mclk;

    // analogue side offers queued words, pops on handshake
    always @(posedge clk) begin
        if (adc_valid && adc_ready) void'(words.pop_front());
        #1;
        adc_valid = (words.size() != 0);
        adc_data  = adc_valid ? words[0] : 16'h0000;
    end

    // count start pulses
    always @(posedge clk) if (rst_n && conv_start === 1'b1) n_starts++;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // all four calibration words, straight 17-clock readout
    task automatic s_cal();
        logic [15:0] w;
        for (int i = 0; i < 4; i++) begin
            u_mcu.send(10, {3'b111, CC[i], 3'b000});
            u_mcu.rd(17, w);
            chk("cal_word", CW[i], w);
            #500;
        end
    endtask

    logic [15:0] adc_data_dummy;

    // unknown code refused, broken frame recovered by the reset pattern
    task automatic s_bad();
        u_mcu.send(10, {3'b111, 4'h0, 3'b000});
        #300 chk("refused_busy", 16'h0, {15'h0, busy});
        u_mcu.send(5, 21'h1E);
        u_mcu.send(21, `BSP_RESET_PAT);
        #300 chk("reset_busy", 16'h0, {15'h0, busy});
        u_mcu.send(10, {3'b111, CC[0], 3'b000});
        u_mcu.rd(17, adc_data_dummy);
        chk("cal_after_reset", CW[0], adc_data_dummy);
    endtask

    // conversion: ack, two clocks, freeze, wait, readout with pause
    task automatic s_conv(input logic [3:0] code, input logic tmp,
                          input logic [15:0] exp, input int pause_at);
        int k;
        int s0;
        logic [15:0] w;
        s0 = n_starts;
        u_mcu.send(10, {3'b111, code, 3'b000});
        chk("ack", 16'h1, {15'h0, dout});
        chk("is_temp", {15'h0, tmp}, {15'h0, conv_is_temp});
        chk("starts", 16'(s0 + 1), 16'(n_starts));
        u_mcu.pulse(1'b0);
        u_mcu.pulse(1'b0);
        @(posedge clk) #1 ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 ce = 1'b1;
        k = 0;
        while (dout !== 1'b0 && k < 30000) begin
            @(posedge clk);
            k++;
        end
        chk("done", 16'h0, {15'h0, dout});
        if (k == 30000) print_verdict();
        u_mcu.rd(pause_at, w);
        chk("result", exp, w);
        #500;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        mclk = 1'b0;
        adc_valid = 1'b0;
        adc_data = 16'h0000;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        s_cal();
        s_bad();
        words = '{16'h8001, 16'h7FFE, 16'hC35A};
        repeat (6) @(posedge clk);
        chk("buf_full", 16'h0, {15'h0, adc_ready});
        s_conv(`BSP_CODE_PRESS, 1'b0, 16'h8001, 17);
        s_conv(`BSP_CODE_TEMP, 1'b1, 16'h7FFE, 9);
        s_conv(`BSP_CODE_PRESS, 1'b0, 16'hC35A, 1);
        print_verdict();
    end
endmodule
